/* File: port_a_params.svh */
// Constants for the port A alternate-function override block.
// Assumes inclusion by the design modules, the checker and the bench of this block.
`ifndef PORT_A_PARAMS_SVH
`define PORT_A_PARAMS_SVH

// Register offsets (byte addresses on the plain register port)
`define MCU_CONTROL_ADDR 8'h35
`define PORT_LATCH_ADDR 8'h3b
`define PORT_DIR_ADDR 8'h3a
`define PORT_PIN_ADDR 8'h39
`define DIGIN_DISABLE_ADDR 8'h40
`define PIN_CHANGE_MASK_ADDR 8'h41
`define ALT_CONTROL_ADDR 8'h42

// Reset values
`define MCU_CONTROL_RESET 8'h00
`define PORT_RESET 8'h00

// Writable bits of the control register: bit 6 and bits 5..3
`define MCU_CONTROL_WMASK 8'h78
`define PULLUP_DISABLE_BIT 6

// Fields of the alternate-function control register
`define ALT_PC_GROUP_BIT 0
`define ALT_THREE_WIRE_BIT 1
`define ALT_RELOCATE_BIT 2
`define ALT_START_IRQ_BIT 3
`define ALT_EXT_EXTERNAL_INTERRUPT_ONE_BIT 4
`define ALT_ANALOG_REFERENCE_PIN_BIT 5
`define ALT_CONTROL_WMASK 8'h3f

// Pin numbers
`define PIN_DATA_IN 0
`define PIN_DATA_OUT 1
`define PIN_CLOCK 2
`define PIN_ANALOG_REFERENCE_PIN 3

`endif

/* File: port_a_pkg.sv */
// Types shared by the port A override block.
// Assumes port_a_params.svh sits in the include path.
package port_a_pkg;
    // Control bits that steer the alternate functions
    typedef struct packed {
        logic arefInUse;
        logic externalInterruptOne;
        logic serialStartIrqEnable;
        logic serialPinRelocate;
        logic threeWireMode;
        logic pinChangeGroupEnable;
    } alt_ctrl_s;

    // Per-pin overrides handed to the pin cells
    typedef struct packed {
        logic [7:0] digoverrideEnable;
        logic [7:0] digoverrideValue;
        logic [7:0] portValueOverrideEnable;
        logic [7:0] portValueOverrideValue;
        logic [7:0] pullupForceOff;
        logic [7:0] driverForceOff;
    } override_s;
endpackage

/* File: pin_sync.sv */
// Two-stage pin synchroniser with digital input gating, one per pin.
// Assumes pins arrive asynchronously to mclk.
`include "port_a_params.svh"
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] gateOff,
    output logic [WIDTH-1:0] pinSynced
);
    logic [WIDTH-1:0] stageOne_reg;
    logic [WIDTH-1:0] stageOne_next;
    logic [WIDTH-1:0] stageTwo_reg;
    logic [WIDTH-1:0] stageTwo_next;

    // Gated buffer reads zero; gating after the second stage keeps
    // the first flop private to the second
    always_comb begin
        stageOne_next = stageOne_reg;
        stageTwo_next = stageTwo_reg;
        if (clkEnable) begin
            stageOne_next = pinIn;
            stageTwo_next = stageOne_reg;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stageOne_reg <= '0;
            stageTwo_reg <= '0;
        end else begin
            stageOne_reg <= stageOne_next;
            stageTwo_reg <= stageTwo_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_gate
            assign pinSynced[i] = stageTwo_reg[i] & ~gateOff[i];
        end
    endgenerate
endmodule

/* File: port_a_alt_function_override.sv */
// Port A alternate-function override: pull-ups, drivers, serial data
// output and digital input gating for an 8-bit port.
// Assumes a plain register port on mclk and pins asynchronous to it.
//
// Implementation choice: the address-and-strobe port.
`include "port_a_params.svh"
module port_a_alt_function_override #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic serialDataOut,
    input wire logic [WIDTH-1:0] padIn,
    output logic [WIDTH-1:0] padOut,
    output logic [WIDTH-1:0] padOe,
    output logic [WIDTH-1:0] padPullup,
    output logic [WIDTH-1:0] pinChangeIn,
    output logic serialDataIn
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] mcuControl_reg, mcuControl_next;
    logic [WIDTH-1:0] portLatch_reg, portLatch_next;
    logic [WIDTH-1:0] portDir_reg, portDir_next;
    logic [WIDTH-1:0] digDisable_reg, digDisable_next;
    logic [WIDTH-1:0] pcMask_reg, pcMask_next;
    logic [7:0] altControl_reg, altControl_next;
    logic [7:0] regRdata_reg, regRdata_next;
    logic [WIDTH-1:0] padOut_reg, padOut_next;
    logic [WIDTH-1:0] padOe_reg, padOe_next;
    logic [WIDTH-1:0] padPullup_reg, padPullup_next;
    logic [WIDTH-1:0] pinSynced;
    port_a_pkg::alt_ctrl_s ctrl;
    port_a_pkg::override_s ovr;
    logic pullupsOff;

    assign ctrl = port_a_pkg::alt_ctrl_s'(altControl_reg[5:0]);
    assign pullupsOff = mcuControl_reg[`PULLUP_DISABLE_BIT];

    // ****************************************************************
    // Override equations
    // ****************************************************************
    // Only bits 0..3 carry alternate overrides; upper pins use the
    // analog disable with pin change, which shares the same pattern
    always_comb begin
        ovr = '0;
        for (int i = 0; i < WIDTH; i++) begin
            ovr.digoverrideEnable[i] =
                (pcMask_reg[i] & ctrl.pinChangeGroupEnable) |
                digDisable_reg[i];
            ovr.digoverrideValue[i] = digDisable_reg[i];
        end
        // Start detector relocated here turns the override on, gating the buffer unless the analog disable is set
        ovr.digoverrideEnable[`PIN_DATA_IN] =
            ovr.digoverrideEnable[`PIN_DATA_IN] |
            (ctrl.serialStartIrqEnable & ctrl.serialPinRelocate);
        ovr.digoverrideEnable[`PIN_CLOCK] =
            ovr.digoverrideEnable[`PIN_CLOCK] |
            ctrl.externalInterruptOne |
            (ctrl.serialStartIrqEnable & ctrl.serialPinRelocate);
        // Reference pin has no analog disable bit in its equations
        ovr.digoverrideEnable[`PIN_ANALOG_REFERENCE_PIN] =
            pcMask_reg[`PIN_ANALOG_REFERENCE_PIN] & ctrl.pinChangeGroupEnable;
        ovr.digoverrideValue[`PIN_ANALOG_REFERENCE_PIN] = 1'b0;
        ovr.portValueOverrideEnable[`PIN_DATA_OUT] =
            ctrl.threeWireMode & ctrl.serialPinRelocate;
        ovr.portValueOverrideValue[`PIN_DATA_OUT] =
            serialDataOut & ctrl.serialPinRelocate;
        ovr.pullupForceOff[`PIN_ANALOG_REFERENCE_PIN] = ctrl.arefInUse;
        ovr.driverForceOff[`PIN_ANALOG_REFERENCE_PIN] = ctrl.arefInUse;
    end

    // ****************************************************************
    // Pad drive
    // ****************************************************************
    // Pads are registered so every output leaves a flop
    always_comb begin
        padOut_next = padOut_reg;
        padOe_next = padOe_reg;
        padPullup_next = padPullup_reg;
        if (clkEnable) begin
            for (int i = 0; i < WIDTH; i++) begin
                padOut_next[i] = ovr.portValueOverrideEnable[i] ?
                    ovr.portValueOverrideValue[i] :
                    portLatch_reg[i];
                // Data-in pin keeps plain direction control
                padOe_next[i] = portDir_reg[i] & ~ovr.driverForceOff[i];
                // Latch still drives the pull-up under the port value override
                padPullup_next[i] = ~portDir_reg[i] & portLatch_reg[i] &
                    ~pullupsOff & ~ovr.pullupForceOff[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            padOut_reg <= '0;
            padOe_reg <= '0;
            padPullup_reg <= '0;
        end else begin
            padOut_reg <= padOut_next;
            padOe_reg <= padOe_next;
            padPullup_reg <= padPullup_next;
        end
    end

    // ****************************************************************
    // Input path
    // ****************************************************************
    // Buffer off only when override active with value zero
    pin_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .clkEnable(clkEnable),
        .pinIn(padIn),
        .gateOff(ovr.digoverrideEnable & ~ovr.digoverrideValue),
        .pinSynced(pinSynced)
    );

    logic [WIDTH-1:0] pinChange_reg, pinChange_next;
    logic serialIn_reg, serialIn_next;

    // Delivered one cycle after sync so the outputs come from flops
    always_comb begin
        pinChange_next = pinChange_reg;
        serialIn_next = serialIn_reg;
        if (clkEnable) begin
            pinChange_next = pinSynced;
            serialIn_next = pinSynced[`PIN_DATA_IN];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pinChange_reg <= '0;
            serialIn_reg <= 1'b0;
        end else begin
            pinChange_reg <= pinChange_next;
            serialIn_reg <= serialIn_next;
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    // Reads answer one cycle later; unmapped addresses read zero
    always_comb begin
        mcuControl_next = mcuControl_reg;
        portLatch_next = portLatch_reg;
        portDir_next = portDir_reg;
        digDisable_next = digDisable_reg;
        pcMask_next = pcMask_reg;
        altControl_next = altControl_reg;
        regRdata_next = regRdata_reg;
        if (clkEnable) begin
            regRdata_next = '0;
            if (regWrite) begin
                unique case (regAddr)
                    `MCU_CONTROL_ADDR: mcuControl_next =
                        regWdata & `MCU_CONTROL_WMASK;
                    `PORT_LATCH_ADDR: portLatch_next = regWdata[WIDTH-1:0];
                    `PORT_DIR_ADDR: portDir_next = regWdata[WIDTH-1:0];
                    `DIGIN_DISABLE_ADDR: digDisable_next =
                        regWdata[WIDTH-1:0];
                    `PIN_CHANGE_MASK_ADDR: pcMask_next = regWdata[WIDTH-1:0];
                    `ALT_CONTROL_ADDR: altControl_next =
                        regWdata & `ALT_CONTROL_WMASK;
                    default: ;
                endcase
            end
            if (regRead) begin
                unique case (regAddr)
                    `MCU_CONTROL_ADDR: regRdata_next = mcuControl_reg;
                    `PORT_LATCH_ADDR: regRdata_next = portLatch_reg;
                    `PORT_DIR_ADDR: regRdata_next = portDir_reg;
                    `PORT_PIN_ADDR: regRdata_next = pinSynced;
                    `DIGIN_DISABLE_ADDR: regRdata_next = digDisable_reg;
                    `PIN_CHANGE_MASK_ADDR: regRdata_next = pcMask_reg;
                    `ALT_CONTROL_ADDR: regRdata_next = altControl_reg;
                    default: regRdata_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mcuControl_reg <= `MCU_CONTROL_RESET;
            portLatch_reg <= `PORT_RESET;
            portDir_reg <= `PORT_RESET;
            digDisable_reg <= `PORT_RESET;
            pcMask_reg <= `PORT_RESET;
            altControl_reg <= `PORT_RESET;
            regRdata_reg <= '0;
        end else begin
            mcuControl_reg <= mcuControl_next;
            portLatch_reg <= portLatch_next;
            portDir_reg <= portDir_next;
            digDisable_reg <= digDisable_next;
            pcMask_reg <= pcMask_next;
            altControl_reg <= altControl_next;
            regRdata_reg <= regRdata_next;
        end
    end

    assign regRdata = regRdata_reg;
    assign padOut = padOut_reg;
    assign padOe = padOe_reg;
    assign padPullup = padPullup_reg;
    assign pinChangeIn = pinChange_reg;
    assign serialDataIn = serialIn_reg;
endmodule

/* File: port_a_checker_assertions.sv */
// Checker for the port A override block, bound to its top module.
// Assumes clkEnable stays high and the register map of the header.
`include "port_a_params.svh"
module port_a_checker #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic serialDataOut,
    input wire logic [WIDTH-1:0] padIn,
    input wire logic [WIDTH-1:0] padOut,
    input wire logic [WIDTH-1:0] padOe,
    input wire logic [WIDTH-1:0] padPullup,
    input wire logic [WIDTH-1:0] pinChangeIn,
    input wire logic serialDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [7:0] latchM, dirM, ddM, altM, ctlM, pcM;
    logic gateZero, gateTwo;

    // ****************************************
    // Register mirror
    // ****************************************
    // Kept from the bus so pad checks need no look inside the block
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {latchM, dirM, ddM, altM, ctlM, pcM} <= 48'h0;
        end else if (regWrite && clkEnable) begin
            case (regAddr)
                `PORT_LATCH_ADDR: latchM <= regWdata;
                `PORT_DIR_ADDR: dirM <= regWdata;
                `DIGIN_DISABLE_ADDR: ddM <= regWdata;
                `ALT_CONTROL_ADDR: altM <= regWdata;
                `MCU_CONTROL_ADDR: ctlM <= regWdata;
                `PIN_CHANGE_MASK_ADDR: pcM <= regWdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Buffer is off where an override is on with value zero; the analog
    // disable sets the value, so it keeps the buffer open
    assign gateZero = ((pcM[0] & altM[0]) | (altM[3] & altM[2])) & ~ddM[0];
    assign gateTwo = ((pcM[2] & altM[0]) | altM[4] | (altM[3] & altM[2]))
        & ~ddM[2];

    // Gate acts after the sync pipe; only the output flop needs to have seen the setting
    sequence ch0_gated;
        gateZero [*4];
    endsequence
    sequence ch0_open;
        (reset_n && !gateZero) [*4];
    endsequence
    a_read_window: assert property (regRdata != 8'h00 |-> $past(regRead))
        else $error("read data outside its cycle");
    a_serial_drive: assert property (
        altM[1] && altM[2] && dirM[1] |=>
        padOe[1] && padOut[1] == $past(serialDataOut))
        else $error("serial out not driven on bit 1");
    a_serial_pullup: assert property (
        altM[1] && altM[2] && !dirM[1] && latchM[1] && !ctlM[6] |=>
        padPullup[1]) else $error("bit 1 pull-up lost");
    a_plain_bit0: assert property (
        padOe[0] == $past(dirM[0]) && padOut[0] == $past(latchM[0]))
        else $error("bit 0 not plain port");
    a_analog_reference_pin_off: assert property (
        altM[5] |=> !padOe[3] && !padPullup[3])
        else $error("reference pin still driven");
    a_pud_all: assert property (ctlM[6] |=> padPullup == 8'h00)
        else $error("pull-up on while disabled");
    a_gate_zero: assert property (
        ch0_gated |-> !pinChangeIn[0])
        else $error("bit 0 buffer not gated");
    a_gate_two: assert property (
        gateTwo [*4] |-> !pinChangeIn[2])
        else $error("bit 2 buffer not gated");
    a_sync_depth: assert property (ch0_open |->
        pinChangeIn[0] == $past(padIn[0], 3) &&
        serialDataIn == $past(padIn[0], 3))
        else $error("bit 0 input path wrong");
endmodule
bind port_a_alt_function_override port_a_checker #(.WIDTH(WIDTH))
    checker_inst (.mclk, .reset_n, .clkEnable, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .serialDataOut, .padIn, .padOut,
    .padOe, .padPullup, .pinChangeIn, .serialDataIn);

/* File: pad_partner.sv */
// Board-side model of the eight port A pins.
// Assumes the bench chooses which pins an outside source drives.
module pad_partner (
    input wire logic mclk,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] padPullup,
    input wire logic [7:0] extDrive,
    input wire logic [7:0] extEn,
    output logic [7:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lastLevel = 8'h00;
    // Block driver wins; a floating pin toggles unless its pull-up holds it high
    assign padIn = (padOe & padOut) | (~padOe & extEn & extDrive)
        | (~padOe & ~extEn & (padPullup | ~lastLevel));
    always @(posedge mclk) lastLevel <= padIn;
endmodule

/* File: port_a_alt_function_override_tb.sv */
// Self-checking bench for the port A override block.
// Assumes the checker is bound by its own file.
`include "port_a_params.svh"
module port_a_alt_function_override_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, padIn;
    logic [7:0] padOut, padOe, padPullup, pinChangeIn, extDrive = 8'h00;
    logic [7:0] extEn = 8'h00, l, d, a, c;
    logic serialDataOut = 1'b0, serialDataIn, look = 1'b0;
    logic rdSeen = 1'b0, lookSeen = 1'b0;
    logic [23:0] expQ[$];
    int failCount = 0, samplesChecked = 0, cycles = 0, seed = 47148;

    // ****************************************
    // Design, pins and clock
    // ****************************************
    port_a_alt_function_override #(
        .WIDTH(8)
    ) port_a_alt_function_override_inst (
        .mclk(mclk), .reset_n(reset_n), .clkEnable(1'b1),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata),
        .serialDataOut(serialDataOut), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padPullup(padPullup), .pinChangeIn(pinChangeIn),
        .serialDataIn(serialDataIn));
    pad_partner pad_partner_inst (.mclk(mclk), .padOut(padOut),
        .padOe(padOe), .padPullup(padPullup), .extDrive(extDrive),
        .extEn(extEn), .padIn(padIn));
    initial forever #10 mclk = ~mclk;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic giveVerdict();
        if (failCount == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
            failCount++;
        end
    endtask
    // One strobe per call; calls may follow with no gap
    task automatic bus(input logic w, input logic r, input logic [7:0] ad,
            input logic [7:0] dt);
        @(posedge mclk);
        regWrite <= w;
        regRead <= r;
        regAddr <= ad;
        regWdata <= dt;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        expQ.push_back({16'h0000, exp});
        bus(1'b0, 1'b1, ad, 8'h00);
    endtask
    // Expected pads; driven value only counts where the pin drives
    function automatic logic [23:0] padsExp(input logic [7:0] lt, dr, al,
            ct, input logic s);
        logic [7:0] o, e, p;
        e = dr;
        o = lt;
        p = ~dr & lt & {8{~ct[`PULLUP_DISABLE_BIT]}};
        if (al[1] && al[2]) o[1] = s;
        if (al[5]) begin
            e[3] = 1'b0;
            p[3] = 1'b0;
        end
        return {o & e, e, p};
    endfunction

    // ****************************************
    // Monitor and timeout
    // ****************************************
    // Compare at the falling edge, clear of the block's own updates
    always @(posedge mclk) begin
        rdSeen <= regRead;
        lookSeen <= look;
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            giveVerdict();
        end
    end
    always @(negedge mclk) begin
        if (rdSeen)
            check({16'h0000, regRdata}, expQ.pop_front());
        if (lookSeen) check({padOut & padOe, padOe, padPullup},
            expQ.pop_front());
    end

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`MCU_CONTROL_ADDR, `MCU_CONTROL_RESET);
        rd(8'h7f, 8'h00);
        bus(1'b1, 1'b0, `MCU_CONTROL_ADDR, 8'hff);
        rd(`MCU_CONTROL_ADDR, `MCU_CONTROL_WMASK);
        bus(1'b1, 1'b0, 8'h7f, 8'hff);
        rd(8'h7f, 8'h00);
        // Every pin driven from the latch, so the pin read is known
        bus(1'b1, 1'b0, `PORT_LATCH_ADDR, 8'ha5);
        bus(1'b1, 1'b0, `PORT_DIR_ADDR, 8'hff);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3) @(posedge mclk);
        rd(`PORT_PIN_ADDR, 8'ha5);
        for (int i = 0; i < 48; i++) begin
            l = 8'($random(seed));
            d = 8'($random(seed));
            a = 8'($random(seed)) & `ALT_CONTROL_WMASK;
            c = 8'($random(seed)) & 8'h40;
            if (i < 12) a[2:1] = 2'b11;
            l[7] = 1'b0; // Comparator pin: input, no pull-up
            d[7] = 1'b0;
            serialDataOut <= 1'($random(seed));
            extDrive <= 8'($random(seed));
            extEn <= 8'($random(seed));
            bus(1'b1, 1'b0, `PORT_LATCH_ADDR, l);
            bus(1'b1, 1'b0, `PORT_DIR_ADDR, d);
            bus(1'b1, 1'b0, `ALT_CONTROL_ADDR, a);
            bus(1'b1, 1'b0, `MCU_CONTROL_ADDR, c);
            bus(1'b1, 1'b0, `DIGIN_DISABLE_ADDR, 8'($random(seed)));
            bus(1'b1, 1'b0, `PIN_CHANGE_MASK_ADDR, 8'($random(seed)));
            rd(`ALT_CONTROL_ADDR, a);
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            repeat (2) @(posedge mclk);
            expQ.push_back(padsExp(l, d, a, c, serialDataOut));
            look <= 1'b1;
            @(posedge mclk);
            look <= 1'b0;
            repeat (5) @(posedge mclk);
        end
        giveVerdict();
    end
endmodule
